//--- rtl/afd_ancillary_extract_insert.sv
// AFD extractor and inserter on a video packet stream, AXI4-Lite registers
// Contract
// - Every ancillary packet is removed; its identifiers are inspected.
// - AFD only when identifier is 0x41 and secondary identifier is 0x5.
// - An AFD packet's payload is decoded into the readable fields.
// - Extract control bit 0: 0 drops everything, 1 forwards all but ancillary.
// - A change in received AFD data sets interrupt bit 1.
// - Writing 1 to interrupt bit 1 clears it and drops the interrupt.
// - Decoded four-bit AFD code reads in bits 3:0.
// - Decoded aspect ratio code reads in bit 0.
// - Four bar flags read in bits 3:0, describing both bar values.
// - Each sixteen-bit bar value reads in bits 15:0 of its register.
// - Present bit is set when the image packet has an AFD code.
// - With insertion on, one AFD packet follows each forwarded control packet.
// - Insert control bit 0: 0 passes unchanged, 1 also inserts.
// - Inserted packet carries the code, aspect, flags and bar values written.
`timescale 1ns/1ns
module afd_ancillary_extract_insert #(
  parameter int DW = afd_pkg::DW
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [DW-1:0] IN_DATA,
  input wire logic IN_SOP,
  input wire logic IN_EOP,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [DW-1:0] OUT_DATA,
  output logic OUT_SOP,
  output logic OUT_EOP,
  output logic IRQ
);
  import afd_pkg::*;

  // Register state
  logic xctl_ff;
  logic ictl_ff;
  logic stat_ff;
  logic mask_ff;
  logic [3:0] x_code_ff;
  logic x_ar_ff;
  logic [3:0] x_flg_ff;
  logic [15:0] x_bar1_ff;
  logic [15:0] x_bar2_ff;
  logic present_ff;
  logic seen_ff;
  logic [3:0] i_code_ff;
  logic i_ar_ff;
  logic [3:0] i_flg_ff;
  logic [15:0] i_bar1_ff;
  logic [15:0] i_bar2_ff;
  // Bus state
  logic aw_got_ff;
  logic w_got_ff;
  logic [5:0] aw_idx_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [31:0] rd_word;
  logic wr_do;
  logic [5:0] ar_idx;
  // Stream state
  ins_state_t state_ff;
  ins_state_t nxt_state;
  logic [4:0] cnt_ff;
  logic [3:0] type_ff;
  logic [3:0] type_now;
  logic take;
  logic fwd;
  logic emit;
  logic ctrl_end;
  logic nxt_out_valid;
  logic [DW-1:0] ins_word;
  // Decoder results
  logic dec_found;
  logic [3:0] dec_code;
  logic dec_ar;
  logic [3:0] dec_flg;
  logic [15:0] dec_bar1;
  logic [15:0] dec_bar2;
  logic differ;
  logic chg_set;
  logic chg_clr;

  // Registers live at aligned words; only listed indexes answer OKAY
  function automatic logic mapped(input logic [5:0] ix);
    case (ix)
      IX_XCTL, IX_XIRQ, IX_XCODE, IX_XAR, IX_XFLG, IX_XBAR1, IX_XBAR2,
      IX_XPRES, IX_XMASK, IX_ICTL, IX_ICODE, IX_IAR, IX_IFLG, IX_IBAR1,
      IX_IBAR2: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Byte-lane merge for the sixteen-bit registers
  function automatic logic [15:0] wm16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    wm16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign wr_do = aw_got_ff && w_got_ff && !BVALID;
  assign ar_idx = ARADDR[7:2];

  // Write address and data are taken in either order
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_idx_ff <= 6'h00;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got_ff <= 1'b1;
        aw_idx_ff <= AWADDR[7:2];
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_got_ff <= 1'b1;
        w_data_ff <= WDATA;
        w_strb_ff <= WSTRB;
        WREADY <= 1'b0;
      end
      if (wr_do) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
      if (BVALID && BREADY) begin
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OK;
    end else if (wr_do) begin
      BVALID <= 1'b1;
      BRESP <= mapped(aw_idx_ff) ? RESP_OK : RESP_ERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Software-written control and inserter values
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      xctl_ff <= CTL_RESET;
      ictl_ff <= CTL_RESET;
      mask_ff <= 1'b0;
      i_code_ff <= 4'h0;
      i_ar_ff <= 1'b0;
      i_flg_ff <= 4'h0;
      i_bar1_ff <= 16'h0000;
      i_bar2_ff <= 16'h0000;
    end else if (wr_do) begin
      case (aw_idx_ff)
        IX_XCTL: if (w_strb_ff[0]) xctl_ff <= w_data_ff[0];
        IX_XMASK: if (w_strb_ff[0]) mask_ff <= w_data_ff[CHG_BIT];
        IX_ICTL: if (w_strb_ff[0]) ictl_ff <= w_data_ff[0];
        IX_ICODE: if (w_strb_ff[0]) i_code_ff <= w_data_ff[3:0];
        IX_IAR: if (w_strb_ff[0]) i_ar_ff <= w_data_ff[0];
        IX_IFLG: if (w_strb_ff[0]) i_flg_ff <= w_data_ff[3:0];
        IX_IBAR1: i_bar1_ff <= wm16(i_bar1_ff, w_data_ff, w_strb_ff);
        IX_IBAR2: i_bar2_ff <= wm16(i_bar2_ff, w_data_ff, w_strb_ff);
        default: ;
      endcase
    end
  end

  // Read mux; reserved and unmapped words read zero
  always_comb begin
    rd_word = 32'h00000000;
    case (ar_idx)
      IX_XCTL: rd_word[0] = xctl_ff;
      IX_XIRQ: rd_word[CHG_BIT] = stat_ff;
      IX_XCODE: rd_word[3:0] = x_code_ff;
      IX_XAR: rd_word[0] = x_ar_ff;
      IX_XFLG: rd_word[3:0] = x_flg_ff;
      IX_XBAR1: rd_word[15:0] = x_bar1_ff;
      IX_XBAR2: rd_word[15:0] = x_bar2_ff;
      IX_XPRES: rd_word[0] = present_ff;
      IX_XMASK: rd_word[CHG_BIT] = mask_ff;
      IX_ICTL: rd_word[0] = ictl_ff;
      IX_ICODE: rd_word[3:0] = i_code_ff;
      IX_IAR: rd_word[0] = i_ar_ff;
      IX_IFLG: rd_word[3:0] = i_flg_ff;
      IX_IBAR1: rd_word[15:0] = i_bar1_ff;
      IX_IBAR2: rd_word[15:0] = i_bar2_ff;
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read data one cycle after the address is taken
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OK;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_word;
      RRESP <= mapped(ar_idx) ? RESP_OK : RESP_ERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // Classify the beat by the type held in its packet's first beat
  assign type_now = IN_SOP ? IN_DATA[3:0] : type_ff;
  assign take = IN_VALID && IN_READY;
  assign fwd = take && xctl_ff && type_now != PT_ANC;
  assign ctrl_end = fwd && IN_EOP && type_now == PT_CTRL && ictl_ff;
  assign emit = state_ff == ST_INS && (!OUT_VALID || OUT_READY);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      type_ff <= PT_VIDEO;
    end else if (take && IN_SOP) begin
      type_ff <= IN_DATA[3:0];
    end
  end

  // Every ancillary beat goes to the decoder, never downstream
  anc_decoder u_dec (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .beat(take && type_now == PT_ANC),
    .sop(IN_SOP),
    .eop(IN_EOP),
    .byte_in(IN_DATA[7:0]),
    .found(dec_found),
    .code(dec_code),
    .aspect(dec_ar),
    .flags(dec_flg),
    .bar1(dec_bar1),
    .bar2(dec_bar2)
  );

  // Load decoded fields when an AFD packet completes
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      x_code_ff <= 4'h0;
      x_ar_ff <= 1'b0;
      x_flg_ff <= 4'h0;
      x_bar1_ff <= 16'h0000;
      x_bar2_ff <= 16'h0000;
    end else if (dec_found) begin
      x_code_ff <= dec_code;
      x_ar_ff <= dec_ar;
      x_flg_ff <= dec_flg;
      x_bar1_ff <= dec_bar1;
      x_bar2_ff <= dec_bar2;
    end
  end

  // Sticky change flag; a new change wins over a same-cycle clear
  assign differ = {dec_code, dec_ar, dec_flg, dec_bar1, dec_bar2} !=
                  {x_code_ff, x_ar_ff, x_flg_ff, x_bar1_ff, x_bar2_ff};
  assign chg_set = dec_found && differ;
  assign chg_clr = wr_do && aw_idx_ff == IX_XIRQ && w_strb_ff[0] && w_data_ff[CHG_BIT];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_ff <= 1'b0;
    end else begin
      stat_ff <= chg_set || (stat_ff && !chg_clr);
    end
  end

  // Interrupt follows the flag gated by the mask bit, one cycle later
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= stat_ff && mask_ff;
    end
  end

  // AFD seen since the last image packet decides its present bit
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      seen_ff <= 1'b0;
      present_ff <= 1'b0;
    end else if (take && IN_SOP && IN_DATA[3:0] == PT_VIDEO) begin
      present_ff <= seen_ff || dec_found;
      seen_ff <= 1'b0;
    end else if (dec_found) begin
      seen_ff <= 1'b1;
    end
  end

  anc_builder u_bld (
    .idx(cnt_ff),
    .code(i_code_ff),
    .aspect(i_ar_ff),
    .flags(i_flg_ff),
    .bar1(i_bar1_ff),
    .bar2(i_bar2_ff),
    .word(ins_word)
  );

  // Insertion sequencer; input stalls while the packet goes out
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_PASS: if (ctrl_end) nxt_state = ST_INS;
      ST_INS: if (emit && cnt_ff == INS_LAST) nxt_state = ST_PASS;
      default: nxt_state = ST_PASS;
    endcase
    nxt_out_valid = fwd || emit || (OUT_VALID && !OUT_READY);
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_PASS;
      cnt_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      if (ctrl_end) begin
        cnt_ff <= 5'h00;
      end else if (emit) begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end

  // Input ready only with an empty output stage, halving throughput
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      IN_READY <= 1'b0;
    end else begin
      IN_READY <= nxt_state == ST_PASS && !nxt_out_valid;
    end
  end

  // Registered output stage
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OUT_VALID <= 1'b0;
      OUT_DATA <= '0;
      OUT_SOP <= 1'b0;
      OUT_EOP <= 1'b0;
    end else if (fwd) begin
      OUT_VALID <= 1'b1;
      OUT_DATA <= IN_DATA;
      OUT_SOP <= IN_SOP;
      OUT_EOP <= IN_EOP;
    end else if (emit) begin
      OUT_VALID <= 1'b1;
      OUT_DATA <= ins_word;
      OUT_SOP <= cnt_ff == 5'h00;
      OUT_EOP <= cnt_ff == INS_LAST;
    end else if (OUT_READY) begin
      OUT_VALID <= 1'b0;
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_anc_drop: assert property (
    take && type_now == PT_ANC |=> !OUT_VALID)
    else $error("Ancillary beat reached the output");
  a_off_drop: assert property (
    take && !xctl_ff |=> !OUT_VALID)
    else $error("Beat forwarded with extract control at zero");
  a_fwd: assert property (
    take && xctl_ff && type_now != PT_ANC |=> OUT_VALID && OUT_DATA == $past(IN_DATA))
    else $error("Non-ancillary beat not forwarded");
  a_load: assert property (
    dec_found |=> x_code_ff == $past(dec_code) && x_bar2_ff == $past(dec_bar2))
    else $error("Decoded fields not loaded");
  a_chg_set: assert property (
    chg_set |=> stat_ff ##1 (IRQ == $past(mask_ff)))
    else $error("Change not flagged");
  a_chg_only: assert property (
    $rose(stat_ff) |-> $past(chg_set))
    else $error("Change flag raised without a differing payload");
  a_clear: assert property (
    chg_clr && !chg_set |=> !stat_ff ##1 !IRQ)
    else $error("Write one did not clear the change flag");
  a_code_rd: assert property (
    ARVALID && ARREADY && ar_idx == IX_XCODE |=> RVALID && RDATA[3:0] == $past(x_code_ff))
    else $error("AFD code read mismatch");
  a_present: assert property (
    take && IN_SOP && IN_DATA[3:0] == PT_VIDEO |=> present_ff == $past(seen_ff || dec_found))
    else $error("Present bit wrong at image start");
  a_ins_start: assert property (
    ctrl_end |=> state_ff == ST_INS && !IN_READY && cnt_ff == 5'h00)
    else $error("Insertion did not follow control packet");
  a_ins_off: assert property (
    state_ff == ST_PASS && !ictl_ff |=> state_ff == ST_PASS)
    else $error("Insertion with insert control at zero");
  a_ins_did: assert property (
    emit && cnt_ff == POS_DID |=> OUT_DATA[7:0] == AFD_DID)
    else $error("Inserted identifier wrong");
endmodule

//--- rtl/afd_pkg.sv
// Shared constants for the AFD ancillary extract and insert block
package afd_pkg;
  // Stream symbol width and packet types
  localparam int DW = 10;
  localparam logic [3:0] PT_VIDEO = 4'h0;
  localparam logic [3:0] PT_ANC = 4'hD;
  localparam logic [3:0] PT_CTRL = 4'hF;
  // Ancillary identifiers and payload layout
  localparam logic [7:0] AFD_DID = 8'h41;
  localparam logic [7:0] AFD_SDID = 8'h05;
  localparam logic [7:0] AFD_DC = 8'h08;
  localparam logic [9:0] ADF_LO = 10'h000;
  localparam logic [9:0] ADF_HI = 10'h3FF;
  localparam logic [4:0] POS_DID = 5'h04;
  localparam logic [4:0] POS_SDID = 5'h05;
  localparam logic [4:0] POS_DC = 5'h06;
  localparam logic [4:0] POS_UDW = 5'h07;
  localparam logic [4:0] POS_MAX = 5'h1F;
  localparam logic [4:0] INS_LAST = 5'h0E;
  // User data word numbers and bit fields
  localparam logic [4:0] UW_AFD = 5'h00;
  localparam logic [4:0] UW_FLG = 5'h03;
  localparam logic [4:0] UW_B1H = 5'h04;
  localparam logic [4:0] UW_B1L = 5'h05;
  localparam logic [4:0] UW_B2H = 5'h06;
  localparam logic [4:0] UW_B2L = 5'h07;
  localparam int CODE_LSB = 3;
  localparam int AR_BIT = 2;
  localparam int FLG_LSB = 4;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] IX_XCTL = 6'h00;
  localparam logic [5:0] IX_XIRQ = 6'h02;
  localparam logic [5:0] IX_XCODE = 6'h03;
  localparam logic [5:0] IX_XAR = 6'h04;
  localparam logic [5:0] IX_XFLG = 6'h05;
  localparam logic [5:0] IX_XBAR1 = 6'h06;
  localparam logic [5:0] IX_XBAR2 = 6'h07;
  localparam logic [5:0] IX_XPRES = 6'h08;
  localparam logic [5:0] IX_XMASK = 6'h09;
  localparam logic [5:0] IX_ICTL = 6'h10;
  localparam logic [5:0] IX_ICODE = 6'h13;
  localparam logic [5:0] IX_IAR = 6'h14;
  localparam logic [5:0] IX_IFLG = 6'h15;
  localparam logic [5:0] IX_IBAR1 = 6'h16;
  localparam logic [5:0] IX_IBAR2 = 6'h17;
  localparam int CHG_BIT = 1;
  localparam logic CTL_RESET = 1'b0;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef enum {ST_PASS, ST_INS} ins_state_t;
endpackage

//--- rtl/anc_builder.sv
// Builds each word of the inserted AFD ancillary packet
`timescale 1ns/1ns
module anc_builder (
  input wire logic [4:0] idx,
  input wire logic [3:0] code,
  input wire logic aspect,
  input wire logic [3:0] flags,
  input wire logic [15:0] bar1,
  input wire logic [15:0] bar2,
  output logic [afd_pkg::DW-1:0] word
);
  import afd_pkg::*;
  logic [7:0] b;

  // Ancillary words carry even parity and its inverse on top
  function automatic logic [9:0] sdi(input logic [7:0] d);
    sdi = {~(^d), ^d, d};
  endfunction

  // Byte per user word; reserved words stay zero
  always_comb begin
    b = 8'h00;
    case (idx - POS_UDW)
      UW_AFD: b = {1'b0, code, aspect, 2'b00};
      UW_FLG: b = {flags, 4'h0};
      UW_B1H: b = bar1[15:8];
      UW_B1L: b = bar1[7:0];
      UW_B2H: b = bar2[15:8];
      UW_B2L: b = bar2[7:0];
      default: b = 8'h00;
    endcase
  end

  // Header words, then user words
  always_comb begin
    case (idx)
      5'h00: word = {6'h00, PT_ANC};
      5'h01: word = ADF_LO;
      5'h02: word = ADF_HI;
      5'h03: word = ADF_HI;
      POS_DID: word = sdi(AFD_DID);
      POS_SDID: word = sdi(AFD_SDID);
      POS_DC: word = sdi(AFD_DC);
      default: word = sdi(b);
    endcase
  end
endmodule

//--- rtl/anc_decoder.sv
// Parses one ancillary packet and stages its AFD fields
`timescale 1ns/1ns
module anc_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic beat,
  input wire logic sop,
  input wire logic eop,
  input wire logic [7:0] byte_in,
  output logic found,
  output logic [3:0] code,
  output logic aspect,
  output logic [3:0] flags,
  output logic [15:0] bar1,
  output logic [15:0] bar2
);
  import afd_pkg::*;
  logic [4:0] idx_ff;
  logic [7:0] did_ff;
  logic [7:0] sdid_ff;
  logic [4:0] uw;
  assign uw = idx_ff - POS_UDW;

  // Word position; the type beat is position zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_ff <= 5'h00;
    end else if (beat) begin
      idx_ff <= sop ? 5'h01 : ((idx_ff == POS_MAX) ? idx_ff : idx_ff + 5'h01);
    end
  end

  // Capture identifiers and user words by position
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      did_ff <= 8'h00;
      sdid_ff <= 8'h00;
      code <= 4'h0;
      aspect <= 1'b0;
      flags <= 4'h0;
      bar1 <= 16'h0000;
      bar2 <= 16'h0000;
    end else if (beat && sop) begin
      // Stale identifiers would let a short packet pass as AFD
      did_ff <= 8'h00;
      sdid_ff <= 8'h00;
    end else if (beat) begin
      if (idx_ff == POS_DID) did_ff <= byte_in;
      if (idx_ff == POS_SDID) sdid_ff <= byte_in;
      if (idx_ff >= POS_UDW) begin
        case (uw)
          UW_AFD: begin
            code <= byte_in[CODE_LSB+:4];
            aspect <= byte_in[AR_BIT];
          end
          UW_FLG: flags <= byte_in[FLG_LSB+:4];
          UW_B1H: bar1[15:8] <= byte_in;
          UW_B1L: bar1[7:0] <= byte_in;
          UW_B2H: bar2[15:8] <= byte_in;
          UW_B2L: bar2[7:0] <= byte_in;
          default: ;
        endcase
      end
    end
  end

  // Pulse once the packet ends, only for the AFD identifiers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      found <= 1'b0;
    end else begin
      found <= beat && eop && !sop && did_ff == AFD_DID && sdid_ff == AFD_SDID;
    end
  end

  a_id_match: assert property (@(posedge clk) disable iff (!rst_n)
    found |-> $past(did_ff) == AFD_DID && $past(sdid_ff) == AFD_SDID)
    else $error("AFD found without matching identifiers");
endmodule

//--- tb/afd_video_sink.sv
// Downstream video sink model that accepts beats promptly or with stalls
`timescale 1ns/1ns
module afd_video_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  output logic ready
);
  logic [15:0] lfsr_ff;
  // Own LFSR, so stalls do not line up with the bench stimulus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_ff <= 16'hACE1;
      ready <= 1'b0;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      ready <= slow ? lfsr_ff[0] : 1'b1;
    end
  end
endmodule

//--- tb/test_afd_ancillary_extract_insert.sv
// Self-checking bench for the AFD extract and insert block
`timescale 1ns/1ns
module test_afd_ancillary_extract_insert;
  import afd_pkg::*;
`define CHK(x, y) begin n_tests++; if ((x) !== (y)) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, x, y); end end
  logic clk = 0, rst_n = 0, slow = 0, out_ready;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, out_valid, out_sop, out_eop, irq, in_ready;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, seed = 32'h7DDA;
  logic [1:0] bresp, rresp, resp;
  logic in_valid = 0, in_sop = 0, in_eop = 0;
  logic [DW-1:0] in_data = 0, out_data;
  logic [DW-1:0] oq[$];
  logic [1:0] sq[$];
  logic [3:0] c = 0, f = 0, oc;
  logic a = 0;
  logic [15:0] b1 = 0, b2 = 0;
  int failures = 0, n_tests = 0, k, i;

  afd_ancillary_extract_insert i_afd_ancillary_extract_insert (.REF_CLK(clk), .RST_N(rst_n),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready),
    .WDATA(wdata), .WSTRB(4'hF), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
    .RDATA(rdata), .RRESP(rresp), .IN_VALID(in_valid), .IN_READY(in_ready),
    .IN_DATA(in_data), .IN_SOP(in_sop), .IN_EOP(in_eop), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_DATA(out_data), .OUT_SOP(out_sop), .OUT_EOP(out_eop),
    .IRQ(irq));
  afd_video_sink i_afd_video_sink (.clk(clk), .rst_n(rst_n), .slow(slow), .ready(out_ready));

  // Clock at 50 MHz
  initial begin
    forever #10 clk = ~clk;
  end

  // Collect every beat the sink accepts; pre-edge values, so no race
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      oq.push_back(out_data);
      sq.push_back({out_sop, out_eop});
    end
  end

  function automatic void step();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
  endfunction

  // Ancillary payload byte at word position i, from the current field set
  function automatic logic [7:0] ab(input int i, input logic [7:0] did);
    case (i)
      1: ab = 8'h00;
      2, 3: ab = 8'hFF;
      4: ab = did;
      5: ab = AFD_SDID;
      6: ab = AFD_DC;
      7: ab = {1'b0, c, a, 2'b00};
      10: ab = {f, 4'h0};
      11: ab = b1[15:8];
      12: ab = b1[7:0];
      13: ab = b2[15:8];
      14: ab = b2[7:0];
      default: ab = 8'h00;
    endcase
  endfunction

  function automatic logic [9:0] mk(input logic [7:0] b);
    mk = {~^b, ^b, b};
  endfunction

  // New field set; code always moves so a change is guaranteed
  task automatic newf();
    step();
    c = c + 4'h1 + {2'b00, seed[1:0]};
    a = seed[4];
    f = seed[8:5];
    b1 = seed[31:16];
    b2 = seed[15:0];
  endtask

  task automatic wr(input logic [5:0] ix, input logic [31:0] v);
    bit ta, tw, bv;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= {ix, 2'b00};
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    forever begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      bv = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (bv) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [5:0] ix);
    bit ta, rv;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= {ix, 2'b00};
    rready <= 1'b1;
    forever begin
      @(negedge clk);
      ta = arvalid & arready;
      rv = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (rv) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic beat(input logic [9:0] w, input logic s, input logic e);
    bit tk;
    @(posedge clk);
    in_valid <= 1'b1;
    in_data <= w;
    in_sop <= s;
    in_eop <= e;
    do begin
      @(negedge clk);
      tk = in_ready;
      @(posedge clk);
    end while (!tk);
    in_valid <= 1'b0;
  endtask

  task automatic anc(input logic [7:0] did);
    beat({6'h00, PT_ANC}, 1'b1, 1'b0);
    for (i = 1; i < 15; i++)
      beat(i == 1 ? ADF_LO : (i < 4 ? ADF_HI : mk(ab(i, did))), 1'b0, i == 14);
  endtask

  // Three-beat packet of the given type with random body words
  task automatic pkt(input logic [3:0] ty);
    step();
    beat({6'h00, ty}, 1'b1, 1'b0);
    beat(seed[9:0], 1'b0, 1'b0);
    beat(seed[19:10], 1'b0, 1'b1);
  endtask

  // Fixed wait, ample even for long stall runs of the slow sink
  task automatic settle();
    repeat (200) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog, well beyond the few thousand cycles the run needs
  initial begin
    #400000;
    failures++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(IX_XCTL);
    `CHK(d, 32'h0)
    rd(IX_ICTL);
    `CHK(d, 32'h0)
    rd(6'h01);
    `CHK(resp, RESP_ERR)
    pkt(PT_VIDEO);
    settle();
    `CHK(oq.size(), 0)
    $display("Test reset and discard done");
    wr(IX_XCTL, 32'h1);
    `CHK(resp, RESP_OK)
    for (k = 0; k < 3; k++) begin
      newf();
      oq.delete();
      anc(AFD_DID);
      pkt(PT_VIDEO);
      settle();
      `CHK(oq.size(), 3)
      rd(IX_XCODE);
      `CHK(d, {28'h0, c})
      rd(IX_XAR);
      `CHK(d, {31'h0, a})
      rd(IX_XFLG);
      `CHK(d, {28'h0, f})
      rd(IX_XBAR1);
      `CHK(d, {16'h0, b1})
      rd(IX_XBAR2);
      `CHK(d, {16'h0, b2})
      rd(IX_XPRES);
      `CHK(d, 32'h1)
      rd(IX_XIRQ);
      `CHK(d[1], 1'b1)
      if (k == 0) begin
        @(negedge clk);
        `CHK(irq, 1'b0)
        wr(IX_XMASK, 32'h2);
      end
      @(negedge clk);
      `CHK(irq, 1'b1)
      wr(IX_XIRQ, 32'h2);
      @(negedge clk);
      `CHK(irq, 1'b0)
      rd(IX_XIRQ);
      `CHK(d[1], 1'b0)
    end
    $display("Test extraction done");
    anc(AFD_DID);
    pkt(PT_VIDEO);
    pkt(PT_VIDEO);
    settle();
    rd(IX_XIRQ);
    `CHK(d[1], 1'b0)
    rd(IX_XPRES);
    `CHK(d, 32'h0)
    oc = c;
    newf();
    anc(8'h42);
    settle();
    rd(IX_XCODE);
    `CHK(d, {28'h0, oc})
    $display("Test repeat and foreign packet done");
    slow = 1'b1;
    wr(IX_ICTL, 32'h1);
    wr(IX_ICODE, {28'h0, c});
    wr(IX_IAR, {31'h0, a});
    wr(IX_IFLG, {28'h0, f});
    wr(IX_IBAR1, {16'h0, b1});
    wr(IX_IBAR2, {16'h0, b2});
    oq.delete();
    sq.delete();
    pkt(PT_CTRL);
    settle();
    `CHK(oq.size(), 18)
    `CHK(sq[3], 2'b10)
    `CHK(sq[17], 2'b01)
    `CHK(oq[3][3:0], PT_ANC)
    for (i = 1; i < 15; i++)
      if (i < 8 || i > 9) `CHK(oq[3 + i][7:0], ab(i, AFD_DID))
    wr(IX_ICTL, 32'h0);
    oq.delete();
    pkt(PT_CTRL);
    settle();
    `CHK(oq.size(), 3)
    $display("Test insertion done");
    summarize();
  end
endmodule
